/* File: core/dct_core.sv */
// Purpose: Front section of one receive down-converter channel.
// Assumes: Samples and APB share CLOCK; SYNC_IN is an async pin.
// Notes: Time-adjust and oscillator step load from shadows on sync.
`timescale 1ns/1ps
module dct_core import dct_pkg::*; (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SYNC_IN,
    input wire logic IN_VALID,
    input wire logic [DCT_DW-1:0] IN_A,
    input wire logic [DCT_DW-1:0] IN_B,
    output logic OUT_VALID,
    output logic [DCT_DW-1:0] OUT_A,
    output logic [DCT_DW-1:0] OUT_B,
    output logic [31:0] NCO_PHASE
);
    typedef struct packed {
        logic [15:0] gain_rate;
        logic [15:0] comb_sel;
        logic [15:0] coarse_sh;
        logic [15:0] fine_sh;
        logic [15:0] step_lo_sh;
        logic [15:0] step_hi_sh;
        logic [15:0] coarse;
        logic [15:0] fine;
        logic [31:0] step;
        logic dual;
        logic pend;
        logic [1:0] sync_ff;
        logic sync_old;
        logic ready;
        logic err;
        logic [31:0] rdata;
        logic [31:0] acc;
        logic [DCT_MEM_DEPTH-1:0][DCT_DW-1:0] mem_a;
        logic [DCT_MEM_DEPTH-1:0][DCT_DW-1:0] mem_b;
        logic [2:0] wp;
        logic [2:0] ph;
        logic [DCT_DW-1:0] hold_a;
        logic [DCT_DW-1:0] hold_b;
        logic [DCT_DW-1:0] stuff_a;
        logic [DCT_DW-1:0] stuff_b;
        logic out_valid;
        logic [DCT_DW-1:0] out_a;
        logic [DCT_DW-1:0] out_b;
    } dct_core_t;

    dct_core_t st, next_st;
    logic cic_valid_a;
    logic [DCT_DW-1:0] cic_a;
    logic [DCT_DW-1:0] cic_b;

    always_comb begin
        logic [6:0] dec;
        logic wr;
        logic sync_ev;
        logic shadow_wr;
        logic [2:0] rp;
        logic [2:0] interp;
        logic [DCT_MEM_DEPTH-1:0][DCT_DW-1:0] nm_a;
        logic [DCT_MEM_DEPTH-1:0][DCT_DW-1:0] nm_b;
        dec = dct_index(PADDR);
        wr = 1'b0;
        sync_ev = 1'b0;
        shadow_wr = 1'b0;
        rp = 3'h0;
        interp = st.fine[POS_INTERP +: 3];
        nm_a = st.mem_a;
        nm_b = st.mem_b;
        next_st = st;

        // APB: answer in the access cycle, one clock after setup
        next_st.ready = PSEL && !PENABLE && !st.ready;
        if (PSEL && !PENABLE && !st.ready) begin
            next_st.err = !dec[6];
            next_st.rdata = RST_WORD;
            if (!PWRITE) begin
                unique case (dec[5:0])
                    IDX_GAIN_RATE: next_st.rdata[15:0] = st.gain_rate;
                    IDX_COMB_SEL: next_st.rdata[15:0] = st.comb_sel;
                    IDX_COARSE: next_st.rdata[15:0] = st.coarse_sh;
                    IDX_FINE: next_st.rdata[15:0] = st.fine_sh;
                    IDX_STEP_LO: next_st.rdata[15:0] = st.step_lo_sh;
                    IDX_STEP_HI: next_st.rdata[15:0] = st.step_hi_sh;
                    IDX_CTRL: begin
                        next_st.rdata[POS_DUAL] = st.dual;
                        next_st.rdata[POS_PEND] = st.pend;
                    end
                    IDX_STATUS: next_st.rdata[15:0] = st.acc[31:16];
                    default: next_st.rdata = RST_WORD;
                endcase
            end
        end
        wr = PSEL && PENABLE && st.ready && PWRITE && dec[6];

        // Synchroniser on the sync pin, edge taken from the second stage
        next_st.sync_ff = {st.sync_ff[0], SYNC_IN};
        next_st.sync_old = st.sync_ff[1];
        sync_ev = st.sync_ff[1] && !st.sync_old;

        if (wr) begin
            unique case (dec[5:0])
                IDX_GAIN_RATE: next_st.gain_rate = PWDATA[15:0];
                IDX_COMB_SEL: next_st.comb_sel = PWDATA[15:0];
                IDX_COARSE: begin
                    next_st.coarse_sh = PWDATA[15:0];
                    shadow_wr = 1'b1;
                end
                IDX_FINE: begin
                    next_st.fine_sh = PWDATA[15:0];
                    shadow_wr = 1'b1;
                end
                IDX_STEP_LO: begin
                    next_st.step_lo_sh = PWDATA[15:0];
                    shadow_wr = 1'b1;
                end
                IDX_STEP_HI: begin
                    next_st.step_hi_sh = PWDATA[15:0];
                    shadow_wr = 1'b1;
                end
                IDX_CTRL: begin
                    next_st.dual = PWDATA[POS_DUAL];
                    sync_ev = sync_ev || PWDATA[POS_SYNC];
                end
                default: next_st.dual = st.dual;
            endcase
        end

        // Load shadows; a write in the same cycle keeps pending set
        if (sync_ev) begin
            next_st.coarse = st.coarse_sh;
            next_st.fine = st.fine_sh;
            next_st.step = {st.step_hi_sh, st.step_lo_sh};
            next_st.pend = 1'b0;
        end
        if (shadow_wr) begin
            next_st.pend = 1'b1;
        end

        // Oscillator accumulator, wraps naturally
        next_st.acc = st.acc + st.step;

        // Coarse delay memory, read relative to the write pointer
        if (IN_VALID) begin
            nm_a[st.wp] = IN_A;
            nm_b[st.wp] = IN_B;
            next_st.mem_a = nm_a;
            next_st.mem_b = nm_b;
            next_st.wp = 3'(st.wp + 3'h1);
            rp = 3'(st.wp - st.coarse[POS_COARSE_A +: 3]);
            next_st.hold_a = nm_a[rp];
            rp = 3'(st.wp - st.coarse[POS_COARSE_B +: 3]);
            next_st.hold_b = st.dual ? nm_b[rp] : '0;
        end

        // Zero stuffing at the clock rate, one phase count for both
        next_st.ph = (st.ph >= interp) ? 3'h0 : 3'(st.ph + 3'h1);
        next_st.stuff_a = (st.ph == st.fine[POS_FINE_A +: 3])
            ? st.hold_a : '0;
        next_st.stuff_b = (st.ph == st.fine[POS_FINE_B +: 3])
            ? st.hold_b : '0;

        // Output stage; B taken on the A strobe, zero when single
        next_st.out_valid = cic_valid_a;
        if (cic_valid_a) begin
            next_st.out_a = cic_a;
            next_st.out_b = st.dual ? cic_b : '0;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    dct_cic #(
        .IW(DCT_DW),
        .OW(DCT_DW),
        .N(DCT_STAGES),
        .GW(DCT_GROWTH)
    ) u_cic_a (
        .CLOCK(CLOCK),
        .RESETN(RESETN),
        .in_valid(1'b1),
        .in_data(st.stuff_a),
        .decim(st.gain_rate[POS_DECIM +: 5]),
        .m2(st.comb_sel[POS_COMB_A +: 6]),
        .scale(st.gain_rate[POS_SCALE_A +: 5]),
        .boost(st.gain_rate[POS_BOOST]),
        .out_valid(cic_valid_a),
        .out_data(cic_a)
    );

    dct_cic #(
        .IW(DCT_DW),
        .OW(DCT_DW),
        .N(DCT_STAGES),
        .GW(DCT_GROWTH)
    ) u_cic_b (
        .CLOCK(CLOCK),
        .RESETN(RESETN),
        // Runs in lockstep with A so both decimate on the same cycle
        .in_valid(1'b1),
        .in_data(st.stuff_b),
        .decim(st.gain_rate[POS_DECIM +: 5]),
        .m2(st.comb_sel[POS_COMB_B +: 6]),
        .scale(st.gain_rate[POS_SCALE_B +: 5]),
        .boost(st.gain_rate[POS_BOOST]),
        .out_valid(),
        .out_data(cic_b)
    );

    assign PRDATA = st.rdata;
    assign PREADY = st.ready;
    assign PSLVERR = st.err;
    assign OUT_VALID = st.out_valid;
    assign OUT_A = st.out_a;
    assign OUT_B = st.out_b;
    assign NCO_PHASE = st.acc;
endmodule : dct_core

/* File: core/dct_pkg.sv */
// Purpose: Shared constants of the down-converter front section.
// Assumes: 16-bit registers in the low half of 32-bit APB words.
// Notes: Register index times four gives the APB byte address.
package dct_pkg;
    localparam int DCT_DW = 16;
    localparam int DCT_STAGES = 6;
    localparam int DCT_GROWTH = 52;
    localparam int DCT_MEM_DEPTH = 8;
    // Register indices
    localparam logic [5:0] IDX_GAIN_RATE = 6'h04;
    localparam logic [5:0] IDX_COMB_SEL = 6'h05;
    localparam logic [5:0] IDX_COARSE = 6'h06;
    localparam logic [5:0] IDX_FINE = 6'h07;
    localparam logic [5:0] IDX_STEP_LO = 6'h08;
    localparam logic [5:0] IDX_STEP_HI = 6'h09;
    localparam logic [5:0] IDX_CTRL = 6'h0A;
    localparam logic [5:0] IDX_STATUS = 6'h0B;
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Field positions
    localparam int POS_SCALE_A = 11;
    localparam int POS_SCALE_B = 6;
    localparam int POS_BOOST = 5;
    localparam int POS_DECIM = 0;
    localparam int POS_COMB_A = 10;
    localparam int POS_COMB_B = 4;
    localparam int POS_COARSE_A = 10;
    localparam int POS_COARSE_B = 4;
    localparam int POS_FINE_A = 13;
    localparam int POS_FINE_B = 10;
    localparam int POS_INTERP = 7;
    localparam int POS_DUAL = 0;
    localparam int POS_SYNC = 1;
    localparam int POS_PEND = 2;
    // Fixed boost of 12 dB is a left shift by two
    localparam logic [5:0] BOOST_SHIFT = 6'h02;

    // Returns {mapped, index} for an APB byte address
    function automatic logic [6:0] dct_index(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        if (addr[1:0] != 2'h0 || idx < IDX_GAIN_RATE || idx > IDX_STATUS) begin
            return 7'h00;
        end
        return {1'b1, idx};
    endfunction : dct_index
endpackage : dct_pkg

/* File: core/dct_cic.sv */
// Purpose: One cascaded integrator-comb decimator with gain shift.
// Assumes: in_valid pulses at the input sample rate.
// Notes: Output is the low word after the shift; no saturation.
`timescale 1ns/1ps
module dct_cic import dct_pkg::*; #(
    parameter int IW = DCT_DW,
    parameter int OW = DCT_DW,
    parameter int N = DCT_STAGES,
    parameter int GW = DCT_GROWTH
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic in_valid,
    input wire logic [IW-1:0] in_data,
    input wire logic [4:0] decim,
    input wire logic [N-1:0] m2,
    input wire logic [4:0] scale,
    input wire logic boost,
    output logic out_valid,
    output logic [OW-1:0] out_data
);
    typedef struct packed {
        logic [N-1:0][GW-1:0] integ;
        logic [N-1:0][GW-1:0] d1;
        logic [N-1:0][GW-1:0] d2;
        logic [4:0] cnt;
        logic ov;
        logic [OW-1:0] od;
    } dct_cic_t;

    dct_cic_t st, next_st;

    always_comb begin
        logic [GW-1:0] x;
        logic [GW-1:0] sh;
        logic [5:0] amt;
        x = '0;
        sh = '0;
        amt = '0;
        next_st = st;
        next_st.ov = 1'b0;
        if (in_valid) begin
            next_st.integ[0] = st.integ[0]
                + {{(GW-IW){in_data[IW-1]}}, in_data};
            for (int i = 1; i < N; i++) begin
                next_st.integ[i] = st.integ[i] + st.integ[i-1];
            end
            if (st.cnt >= decim) begin
                next_st.cnt = 5'h00;
                x = st.integ[N-1];
                for (int i = 0; i < N; i++) begin
                    next_st.d2[i] = st.d1[i];
                    next_st.d1[i] = x;
                    // Delay of two or one per section
                    x = x - (m2[i] ? st.d2[i] : st.d1[i]);
                end
                amt = {1'b0, scale} + (boost ? BOOST_SHIFT : 6'h00);
                sh = x << amt;
                next_st.od = sh[OW-1:0];
                next_st.ov = 1'b1;
            end else begin
                next_st.cnt = 5'(st.cnt + 5'h01);
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out_valid = st.ov;
    assign out_data = st.od;
endmodule : dct_cic

/* File: verif/dct_core_checker.sv */
// Purpose: Port-level checks of the down-converter front section.
// Assumes: Zero-wait APB slave; step word changes only on sync.
// Notes: Attached to dct_core by the bind after the module.
`timescale 1ns/1ps
module dct_core_checker import dct_pkg::*; (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic SYNC_IN,
    input wire logic OUT_VALID,
    input wire logic [DCT_DW-1:0] OUT_A,
    input wire logic [DCT_DW-1:0] OUT_B,
    input wire logic [31:0] NCO_PHASE
);
    logic [2:0] quiet;
    logic bad_addr;
    logic setup;
    assign setup = PSEL && !PENABLE;
    assign bad_addr = PADDR[1:0] != 2'h0 || PADDR[7:2] < IDX_GAIN_RATE
        || PADDR[7:2] > IDX_STATUS;
    // Cycles since the last write or sync pin activity
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            quiet <= 3'h0;
        end else if ((PSEL && PWRITE) || SYNC_IN) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    chk_ready_setup: assert property (
        setup |=> PREADY)
        else $error("no answer after setup cycle");
    chk_ready_pulse: assert property (
        PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_ready_access: assert property (
        PREADY |-> PSEL && PENABLE)
        else $error("ready outside an access");
    chk_err_unmapped: assert property (
        setup && bad_addr |=> PSLVERR)
        else $error("no error on unmapped address");
    chk_err_mapped: assert property (
        setup && !bad_addr |=> !PSLVERR)
        else $error("error on mapped address");
    chk_rdata_upper: assert property (
        PREADY |-> PRDATA[31:16] == 16'h0)
        else $error("upper read data not zero");
    chk_nco_step: assert property (
        quiet >= 3'h6 |->
        (NCO_PHASE - $past(NCO_PHASE))
        == ($past(NCO_PHASE) - $past(NCO_PHASE, 2)))
        else $error("accumulator step changed without sync");
    chk_reset_clear: assert property (
        $rose(RESETN) |->
        NCO_PHASE == 32'h0 && !OUT_VALID && OUT_A == 16'h0
        && OUT_B == 16'h0)
        else $error("outputs not clear after reset");
    chk_out_hold: assert property (
        !OUT_VALID |-> $stable(OUT_A) && $stable(OUT_B))
        else $error("outputs moved without valid");
endmodule : dct_core_checker

bind dct_core dct_core_checker i_chk (.CLOCK(CLOCK), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SYNC_IN(SYNC_IN), .OUT_VALID(OUT_VALID), .OUT_A(OUT_A),
    .OUT_B(OUT_B), .NCO_PHASE(NCO_PHASE));

/* File: verif/dct_src_model.sv */
// Purpose: Upstream sample source feeding both input streams.
// Assumes: One sample per clock after reset.
// Notes: Levels come from the bench; reset gives inverted idle data.
`timescale 1ns/1ps
module dct_src_model import dct_pkg::*; (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [DCT_DW-1:0] lvl_a,
    input wire logic [DCT_DW-1:0] lvl_b,
    output logic in_valid,
    output logic [DCT_DW-1:0] in_a,
    output logic [DCT_DW-1:0] in_b
);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            in_valid <= 1'b0;
            in_a <= 16'hA5A5;
            in_b <= 16'h5A5A;
        end else begin
            in_valid <= 1'b1;
            in_a <= lvl_a;
            in_b <= lvl_b;
        end
    end
endmodule : dct_src_model

/* File: verif/dct_core_bench.sv */
// Purpose: Self-checking bench of the down-converter front section.
// Assumes: DC input levels; steady outputs after settling.
// Notes: One task per scenario; APB master with zero idle assumptions.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
n_mismatch++; $display("mismatch t=%0t got %0h exp %0h", $time, \
(a), (b)); end end
module dct_core_bench import dct_pkg::*;;
    logic clock, resetn, psel, penable, pwrite, sync_in, e;
    logic in_valid, out_valid, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, nco_phase, r, p0, dlt;
    logic [DCT_DW-1:0] in_a, in_b, out_a, out_b, lvl_a, lvl_b;
    int n_mismatch, total_checks, n0, n1;
    int cycles = 0;
    localparam logic [7:0] BAD [4] = '{8'h00, 8'h0C, 8'h11, 8'h30};
    // Dual, gain_rate, comb, fine, expected A, expected B
    localparam logic [15:0] TBL [12][6] = '{
        '{16'h0, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000},
        '{16'h0, 16'h1800, 16'h0000, 16'h0000, 16'h0008, 16'h0000},
        '{16'h0, 16'h0020, 16'h0000, 16'h0000, 16'h0004, 16'h0000},
        '{16'h0, 16'h0001, 16'h0000, 16'h0000, 16'h0040, 16'h0000},
        '{16'h0, 16'h0003, 16'h0000, 16'h0000, 16'h1000, 16'h0000},
        '{16'h0, 16'h0000, 16'h0400, 16'h0000, 16'h0002, 16'h0000},
        '{16'h0, 16'h0000, 16'hFC00, 16'h0000, 16'h0040, 16'h0000},
        '{16'h1, 16'h0080, 16'h0200, 16'h0000, 16'h0001, 16'h0008},
        '{16'h1, 16'h0001, 16'h0000, 16'h0080, 16'h0020, 16'h0020},
        '{16'h1, 16'h0001, 16'h0000, 16'h6080, 16'h0000, 16'h0020},
        '{16'h1, 16'h0001, 16'h0000, 16'h0C80, 16'h0020, 16'h0000},
        '{16'h0, 16'h0007, 16'h0000, 16'h0380, 16'h8000, 16'h0000}};

    dct_core i_dut (.CLOCK(clock), .RESETN(resetn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SYNC_IN(sync_in), .IN_VALID(in_valid),
        .IN_A(in_a), .IN_B(in_b), .OUT_VALID(out_valid), .OUT_A(out_a),
        .OUT_B(out_b), .NCO_PHASE(nco_phase));
    dct_src_model i_src (.clock(clock), .resetn(resetn), .lvl_a(lvl_a),
        .lvl_b(lvl_b), .in_valid(in_valid), .in_a(in_a), .in_b(in_b));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test;
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cfg(input logic d, input logic [15:0] gr, cb, co, fi);
        apb(1'b1, 8'h10, gr);
        apb(1'b1, 8'h14, cb);
        apb(1'b1, 8'h18, co);
        apb(1'b1, 8'h1C, fi);
        apb(1'b1, 8'h28, {14'h0, 1'b1, d});
        repeat (100) @(posedge clock);
    endtask : cfg

    task automatic meas;
        repeat (4) @(posedge clock);
        p0 = nco_phase;
        @(posedge clock);
        dlt = nco_phase - p0;
    endtask : meas

    task automatic t_reset;
        for (int a = 16; a <= 40; a += 4) begin
            apb(1'b0, 8'(a), 16'h0);
            `CHK(r, RST_WORD)
        end
        `CHK(nco_phase, RST_WORD)
        $display("test reset done");
    endtask : t_reset

    task automatic t_refuse;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, BAD[i], 16'h0);
            `CHK(e, 1'b1)
            `CHK(r, RST_WORD)
        end
        apb(1'b1, 8'h2C, 16'hFFFF);
        `CHK(e, 1'b0)
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_nco;
        apb(1'b1, 8'h20, 16'h0003);
        apb(1'b1, 8'h24, 16'h0001);
        repeat (5) @(posedge clock);
        `CHK(nco_phase, RST_WORD)
        apb(1'b0, 8'h24, 16'h0);
        `CHK(r, 32'h0000_0001)
        apb(1'b0, 8'h28, 16'h0);
        `CHK(r[2], 1'b1)
        apb(1'b1, 8'h28, 16'h0002);
        meas;
        `CHK(dlt, 32'h0001_0003)
        apb(1'b1, 8'h20, 16'h0005);
        meas;
        `CHK(dlt, 32'h0001_0003)
        sync_in <= 1'b1;
        repeat (6) @(posedge clock);
        sync_in <= 1'b0;
        meas;
        `CHK(dlt, 32'h0001_0005)
        apb(1'b1, 8'h20, 16'hFFFF);
        apb(1'b1, 8'h24, 16'hFFFF);
        apb(1'b1, 8'h28, 16'h0002);
        meas;
        `CHK(dlt, 32'hFFFF_FFFF)
        apb(1'b0, 8'h28, 16'h0);
        `CHK(r[2], 1'b0)
        $display("test oscillator done");
    endtask : t_nco

    task automatic t_stream;
        for (int i = 0; i < 12; i++) begin
            cfg(TBL[i][0][0], TBL[i][1], TBL[i][2], 16'h0, TBL[i][3]);
            `CHK(out_a, TBL[i][4])
            `CHK(out_b, TBL[i][5])
            n0 = 0;
            repeat (32) begin
                @(posedge clock);
                if (out_valid === 1'b1) begin
                    n0++;
                end
            end
            `CHK(n0, 32 / (TBL[i][1][4:0] + 1))
        end
        $display("test decimator done");
    endtask : t_stream

    task automatic lat(input logic s, input logic [2:0] k, output int n);
        cfg(1'b1, 16'h0, 16'h0, s ? {9'h0, k, 4'h0} : {3'h0, k, 10'h0},
            16'h0);
        lvl_a <= 16'h0;
        lvl_b <= 16'h0;
        repeat (60) @(posedge clock);
        lvl_a <= 16'h1;
        lvl_b <= 16'h1;
        n = 0;
        @(posedge clock);
        while ((s ? out_b : out_a) === 16'h0 && n < 100) begin
            @(posedge clock);
            n++;
        end
    endtask : lat

    task automatic t_coarse;
        for (int s = 0; s < 2; s++) begin
            lat(s[0], 3'h0, n0);
            lat(s[0], 3'h3, n1);
            `CHK(n1 - n0, 3)
        end
        $display("test coarse delay done");
    endtask : t_coarse

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sync_in = 1'b0;
        lvl_a = 16'h1;
        lvl_b = 16'h1;
        n_mismatch = 0;
        total_checks = 0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        t_reset;
        t_refuse;
        t_nco;
        t_stream;
        t_coarse;
        stop_test;
    end
endmodule : dct_core_bench
